// ===== design/uft_pkg.sv
// package: constants for the usb frame timer block
package uft_pkg;
  // register addresses, index times four on the byte-addressed register port
  localparam logic [7:0] FRAME_TIME_LEFT_IDX = 8'h0e;
  localparam logic [7:0] FRAME_COUNT_IDX     = 8'h0f;
  localparam logic [7:0] LOWSPEED_CUTOFF_IDX = 8'h11;
  localparam logic [7:0] FRAME_PERIOD_IDX    = 8'h0d;
  localparam logic [7:0] IRQ_FLAG_IDX        = 8'h03;
  localparam logic [7:0] IRQ_MASK_IDX        = 8'h04;
  localparam logic [7:0] CONTROL_IDX         = 8'h05;
  localparam logic [9:0] ADDR_SCALE          = 10'h004;

  // field layout
  localparam int BTL_W      = 14;
  localparam int FIDX_W     = 16;
  localparam int LSL_W      = 11;
  localparam int TOGGLE_BIT = 31;
  localparam int NFRAME_BIT = 2;
  localparam int OPER_BIT   = 0;

  // reset values
  localparam logic [13:0] FRAME_PERIOD_RST = 14'h2edf; // 11999
  localparam logic [10:0] LOWSPEED_RST     = 11'h628;
  localparam logic [31:0] IRQ_MASK_RST     = 32'h0000_0000;

  // timing
  localparam int CLK_HZ     = 125_000_000;
  localparam int BIT_HZ     = 12_000_000;
  localparam int TICK_ACC_W = 28;

  typedef enum logic [1:0] {
    UFT_HALTED = 2'b00,
    UFT_ENTER  = 2'b01,
    UFT_RUN    = 2'b10
  } uft_state_type;
endpackage : uft_pkg

// ===== design/uft_tick.sv
// bit-time tick generator: fractional divider from core clock
`timescale 1ns/100ps
module uft_tick #(
  parameter int CLK_HZ = uft_pkg::CLK_HZ,
  parameter int BIT_HZ = uft_pkg::BIT_HZ
) (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  localparam int W = uft_pkg::TICK_ACC_W;
  localparam logic [W-1:0] STEP = W'(BIT_HZ);
  localparam logic [W-1:0] WRAP = W'(CLK_HZ);

  logic [W-1:0] acc_q;
  logic [W:0]   sum;

  // phase accumulator keeps long-term rate exact; tick jitters by one clock
  assign sum = {1'b0, acc_q} + {1'b0, STEP};

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      acc_q  <= '0;
      tick_o <= 1'b0;
    end else if (sum >= {1'b0, WRAP}) begin
      acc_q  <= W'(sum - {1'b0, WRAP});
      tick_o <= 1'b1; // see RQ17
    end else begin
      acc_q  <= sum[W-1:0];
      tick_o <= 1'b0;
    end
  end
endmodule : uft_tick

// ===== design/uft_sticky.sv
// one sticky status bit: set wins over write-one-to-clear
`timescale 1ns/100ps
module uft_sticky (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end
endmodule : uft_sticky

// ===== design/uft_frame_timer.sv
// top: frame timer with register port, low-speed gate and interrupt
//
// Operation
// RQ1: 14-bit counter decrements each bit time
// RQ2: at zero, reload frame period next tick
// RQ3: copy interval toggle into bit 31
// RQ4: entering operational loads counter from period
// RQ5: frame index increments on each reload
// RQ6: frame index wraps ffff to 0000
// RQ7: entering operational increments frame index once
// RQ8: frame advance sets new-frame status flag
// RQ9: low-speed start only if count >= limit
// RQ10: lowspeed limit is an 11-bit value
// RQ11: limit changes only by register write
// RQ12: limit read code 11, write 91
// RQ13: frame_time_left read-only, reserved reads zero
// RQ14: frame_count read-only, upper half zero
// RQ15: frame period defaults 11999, reset restores
// RQ16: software toggles bit when changing period
// RQ17: bit tick derived at 12 Mbit/s
// RQ18: counters hold outside operational state
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
module uft_frame_timer #(
  parameter int CLK_HZ = uft_pkg::CLK_HZ,
  parameter int BIT_HZ = uft_pkg::BIT_HZ
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic [9:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        ls_req_i,
  output logic             ls_go_o,
  output logic             tick_o,
  output logic             irq_o
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  localparam int BW = uft_pkg::BTL_W;
  localparam int FW = uft_pkg::FIDX_W;
  localparam int LW = uft_pkg::LSL_W;
  localparam int TB = uft_pkg::TOGGLE_BIT;

  logic [BW-1:0]  bit_times_left_q;
  logic [FW-1:0]  frame_index_q;
  logic           remaining_toggle_q;
  logic [BW-1:0]  frame_period_q;
  logic           interval_toggle_q;
  logic [LW-1:0]  lowspeed_limit_q;
  logic           oper_req_q;
  logic [31:0]    irq_mask_q;
  uft_pkg::uft_state_type state_q;
  uft_pkg::uft_state_type state_d;

  logic          tick;
  logic          new_frame_flag;
  logic          frame_adv;
  logic          entering;
  logic          running;
  logic          wr_period;
  logic          wr_limit;
  logic          wr_irq;
  logic          wr_mask;
  logic          wr_ctrl;
  logic [31:0]   irq_status;
  logic [31:0]   rd_mux;
  logic          last_bit;
  logic          sel_time_left;
  logic          sel_count;
  logic          sel_cutoff;
  logic          sel_period;
  logic          sel_irq;
  logic          sel_mask;
  logic          sel_ctrl;
  logic [31:0]   time_left_img;
  logic [31:0]   count_img;
  logic [31:0]   cutoff_img;
  logic [31:0]   period_img;
  logic [31:0]   ctrl_img;

  // ****************************************************************
  // register decode
  // ****************************************************************
  function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
    hit = (a == 10'(idx) * uft_pkg::ADDR_SCALE);
  endfunction : hit

  assign wr_period = wr_i && hit(addr_i, uft_pkg::FRAME_PERIOD_IDX);
  assign wr_limit  = wr_i && hit(addr_i, uft_pkg::LOWSPEED_CUTOFF_IDX);
  assign wr_irq    = wr_i && hit(addr_i, uft_pkg::IRQ_FLAG_IDX);
  assign wr_mask   = wr_i && hit(addr_i, uft_pkg::IRQ_MASK_IDX);
  assign wr_ctrl   = wr_i && hit(addr_i, uft_pkg::CONTROL_IDX);

  // ****************************************************************
  // read select
  // ****************************************************************
  // one select per register keeps the read mux flat
  assign sel_time_left = hit(addr_i, uft_pkg::FRAME_TIME_LEFT_IDX);
  assign sel_count     = hit(addr_i, uft_pkg::FRAME_COUNT_IDX);
  assign sel_cutoff    = hit(addr_i, uft_pkg::LOWSPEED_CUTOFF_IDX);
  assign sel_period    = hit(addr_i, uft_pkg::FRAME_PERIOD_IDX);
  assign sel_irq       = hit(addr_i, uft_pkg::IRQ_FLAG_IDX);
  assign sel_mask      = hit(addr_i, uft_pkg::IRQ_MASK_IDX);
  assign sel_ctrl      = hit(addr_i, uft_pkg::CONTROL_IDX);

  // ****************************************************************
  // bit-time tick
  // ****************************************************************
  uft_tick #(
    .CLK_HZ (CLK_HZ),
    .BIT_HZ (BIT_HZ)
  ) u_tick (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .tick_o     (tick)
  ); // see RQ17

  // registered again so the pin carries no divider compare logic
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= tick;
    end
  end

  // ****************************************************************
  // operational state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      uft_pkg::UFT_HALTED: begin
        if (oper_req_q) begin
          state_d = uft_pkg::UFT_ENTER;
        end
      end
      uft_pkg::UFT_ENTER: begin
        state_d = oper_req_q ? uft_pkg::UFT_RUN : uft_pkg::UFT_HALTED;
      end
      uft_pkg::UFT_RUN: begin
        if (!oper_req_q) begin
          state_d = uft_pkg::UFT_HALTED;
        end
      end
      default: begin
        state_d = uft_pkg::UFT_HALTED;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= uft_pkg::UFT_HALTED;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // state decode
  // ****************************************************************
  // enter lasts one cycle, so the load and first increment happen once
  assign entering = (state_q == uft_pkg::UFT_ENTER);
  assign running  = (state_q == uft_pkg::UFT_RUN);

  // ****************************************************************
  // software registers
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      frame_period_q    <= uft_pkg::FRAME_PERIOD_RST; // see RQ15
      interval_toggle_q <= 1'b0;
    end else if (wr_period) begin
      frame_period_q    <= wdata_i[BW-1:0];
      interval_toggle_q <= wdata_i[TB]; // see RQ16
    end
  end

  // the limit is only ever touched by this write path
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lowspeed_limit_q <= uft_pkg::LOWSPEED_RST;
    end else if (wr_limit) begin
      lowspeed_limit_q <= wdata_i[LW-1:0]; // see RQ10 see RQ11 see RQ12
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      oper_req_q <= 1'b0;
    end else if (wr_ctrl) begin
      oper_req_q <= wdata_i[uft_pkg::OPER_BIT];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_mask_q <= uft_pkg::IRQ_MASK_RST;
    end else if (wr_mask) begin
      irq_mask_q <= wdata_i;
    end
  end

  // ****************************************************************
  // frame counters
  // ****************************************************************
  // a reload waits for the bit time after zero was reached
  assign frame_adv = running && tick && (bit_times_left_q == '0); // see RQ2
  assign last_bit  = running && tick && (bit_times_left_q == BW'(1));

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bit_times_left_q <= '0;
    end else if (entering) begin
      bit_times_left_q <= frame_period_q; // see RQ4
    end else if (frame_adv) begin
      bit_times_left_q <= frame_period_q; // see RQ2
    end else if (running && tick) begin // see RQ18
      bit_times_left_q <= bit_times_left_q - 1'b1; // see RQ1
    end
  end

  // copied as the count steps onto zero, so it marks the closing bit time
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      remaining_toggle_q <= 1'b0;
    end else if (last_bit) begin
      remaining_toggle_q <= interval_toggle_q; // see RQ3
    end
  end

  // wrap is natural modulo arithmetic, no saturation
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      frame_index_q <= '0;
    end else if (entering || frame_adv) begin
      frame_index_q <= frame_index_q + 1'b1; // see RQ5 see RQ6 see RQ7
    end
  end

  // ****************************************************************
  // low-speed start gate
  // ****************************************************************
  // gate is a one-cycle go answer to a one-cycle request
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ls_go_o <= 1'b0;
    end else begin
      ls_go_o <= ls_req_i && running &&
                 (bit_times_left_q >= BW'(lowspeed_limit_q)); // see RQ9
    end
  end

  // ****************************************************************
  // interrupt status
  // ****************************************************************
  uft_sticky u_new_frame (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .set_i      (entering || frame_adv),
    .clr_i      (wr_irq && wdata_i[uft_pkg::NFRAME_BIT]),
    .flag_o     (new_frame_flag)
  ); // see RQ8

  always_comb begin
    irq_status = '0;
    irq_status[uft_pkg::NFRAME_BIT] = new_frame_flag;
  end

  // ****************************************************************
  // interrupt output
  // ****************************************************************
  // level output, drops the cycle after the last unmasked flag clears
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_mask_q);
    end
  end

  // ****************************************************************
  // register images
  // ****************************************************************
  // reserved bits are tied low here so every read path agrees
  always_comb begin
    time_left_img         = '0;
    time_left_img[BW-1:0] = bit_times_left_q; // see RQ13
    time_left_img[TB]     = remaining_toggle_q;
  end

  always_comb begin
    count_img         = '0;
    count_img[FW-1:0] = frame_index_q; // see RQ14
  end

  always_comb begin
    cutoff_img         = '0;
    cutoff_img[LW-1:0] = lowspeed_limit_q; // see RQ12
  end

  always_comb begin
    period_img         = '0;
    period_img[BW-1:0] = frame_period_q;
    period_img[TB]     = interval_toggle_q;
  end

  always_comb begin
    ctrl_img                    = '0;
    ctrl_img[uft_pkg::OPER_BIT] = oper_req_q;
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  always_comb begin
    rd_mux = '0;
    if (sel_time_left) begin
      rd_mux = time_left_img;
    end else if (sel_count) begin
      rd_mux = count_img;
    end else if (sel_cutoff) begin
      rd_mux = cutoff_img;
    end else if (sel_period) begin
      rd_mux = period_img;
    end else if (sel_irq) begin
      rd_mux = irq_status;
    end else if (sel_mask) begin
      rd_mux = irq_mask_q;
    end else if (sel_ctrl) begin
      rd_mux = ctrl_img;
    end
  end

  // data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rd_i ? rd_mux : '0;
    end
  end
endmodule : uft_frame_timer

// ===== bench/uft_frame_timer_chk.sv
// checker: port properties of the frame timer
`timescale 1ns/100ps
module uft_frame_timer_chk #(
  parameter int CLK_HZ = uft_pkg::CLK_HZ,
  parameter int BIT_HZ = uft_pkg::BIT_HZ
) (
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic [9:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        ls_req_i,
  input wire logic        ls_go_o,
  input wire logic        tick_o,
  input wire logic        irq_o
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  AST_RST_OUT:
    assert property ($fell(rst_i) |-> rdata_o == 32'h0 && !ls_go_o && !irq_o)
    else $error("outputs not clear after reset");
  AST_RD_IDLE:
    assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data outside read slot");
  AST_FTL_RSV:
    assert property (rd_i && addr_i == 10'h038 |=> rdata_o[30:14] == 17'h0)
    else $error("reserved time-left bits set");
  AST_FCNT_RSV:
    assert property (rd_i && addr_i == 10'h03c |=> rdata_o[31:16] == 16'h0)
    else $error("reserved frame count bits set");
  AST_LSL_RSV:
    assert property (rd_i && addr_i == 10'h044 |=> rdata_o[31:11] == 21'h0)
    else $error("reserved cutoff bits set");
  AST_LS_NOREQ:
    assert property (!ls_req_i |=> !ls_go_o)
    else $error("low-speed go without request");
  AST_TICK_PULSE:
    assert property (tick_o |=> !tick_o)
    else $error("tick longer than one cycle");
  // 125/12 gives gaps of 10 or 11 cycles; accepts 9 to 11, one cycle of slack below, none above
  AST_TICK_GAP:
    assert property (tick_o |=> (!tick_o) [*8] ##[1:3] tick_o)
    else $error("tick spacing off the bit rate");
endmodule : uft_frame_timer_chk

bind uft_frame_timer uft_frame_timer_chk #(
  .CLK_HZ(CLK_HZ),
  .BIT_HZ(BIT_HZ)
) u_chk (
  .core_clk_i(core_clk_i),
  .rst_i     (rst_i),
  .addr_i    (addr_i),
  .wdata_i   (wdata_i),
  .wr_i      (wr_i),
  .rd_i      (rd_i),
  .rdata_o   (rdata_o),
  .ls_req_i  (ls_req_i),
  .ls_go_o   (ls_go_o),
  .tick_o    (tick_o),
  .irq_o     (irq_o)
);

// ===== bench/uft_frame_timer_tb_top.sv
// testbench: random and corner stimulus for the frame timer
`timescale 1ns/100ps
module uft_frame_timer_tb_top;
  localparam logic [13:0] PA = 14'd40;
  localparam logic [13:0] PB = 14'd25;
  logic        core_clk_i, rst_i, wr_i, rd_i, ls_req_i, ls_go_o, tick_o;
  logic        irq_o, g;
  logic [9:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, v, w, u, seed;
  int          err_total, checks, tcnt, t0, i, k;

  uft_frame_timer dut (
    .core_clk_i(core_clk_i),
    .rst_i     (rst_i),
    .addr_i    (addr_i),
    .wdata_i   (wdata_i),
    .wr_i      (wr_i),
    .rd_i      (rd_i),
    .rdata_o   (rdata_o),
    .ls_req_i  (ls_req_i),
    .ls_go_o   (ls_go_o),
    .tick_o    (tick_o),
    .irq_o     (irq_o)
  );

  // ****************
  // helpers
  // ****************
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    if (tick_o === 1'b1) tcnt <= tcnt + 1;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] x, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= {x, 2'b00};
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] x, input logic l);
    @(posedge core_clk_i);
    addr_i <= {x, 2'b00};
    rd_i <= 1'b1;
    ls_req_i <= l;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    ls_req_i <= 1'b0;
    #1;
    v = rdata_o;
    g = ls_go_o;
  endtask : rd
  // park mid bit time so a tick never races a captured count
  task automatic ts();
    repeat (12) begin
      @(posedge core_clk_i);
      #1;
      if (tick_o === 1'b1) break;
    end
    repeat (2) @(posedge core_clk_i);
  endtask : ts
  task automatic clr();
    wr(uft_pkg::IRQ_FLAG_IDX, 32'h4);
    repeat (2) @(posedge core_clk_i);
  endtask : clr
  task automatic wirq(input int n);
    for (k = 0; k < 2000 && irq_o !== 1'b1; k++) begin
      @(posedge core_clk_i);
      #1;
    end
    chk({31'h0, irq_o}, 32'h1);
    if (n != 0) chk(32'(tcnt - t0), 32'(n));
    t0 = tcnt;
  endtask : wirq
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  initial begin
    repeat (60000) @(posedge core_clk_i);
    err_total++;
    final_report();
  end

  // ****************
  // tests
  // ****************
  initial begin
    seed = 32'h2537;
    {rst_i, wr_i, rd_i, ls_req_i} = 4'b1000;
    addr_i = 10'h000;
    wdata_i = 32'h0;
    {err_total, checks, tcnt, t0} = '0;
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(uft_pkg::LOWSPEED_CUTOFF_IDX, 1'b0);
    chk(v, 32'h628);
    rd(uft_pkg::FRAME_PERIOD_IDX, 1'b1);
    chk(v, 32'h2edf);
    chk({31'h0, g}, 32'h0);
    wr(uft_pkg::FRAME_COUNT_IDX, rnd());
    wr(uft_pkg::FRAME_TIME_LEFT_IDX, rnd());
    rd(uft_pkg::FRAME_COUNT_IDX, 1'b0);
    chk(v, 32'h0);
    rd(uft_pkg::FRAME_TIME_LEFT_IDX, 1'b0);
    chk(v, 32'h0);
    rd(8'hff, 1'b0);
    chk(v, 32'h0);
    $display("test reset done");
    wr(uft_pkg::FRAME_PERIOD_IDX, {1'b1, 17'h0, PA});
    wr(uft_pkg::CONTROL_IDX, 32'h1);
    repeat (4) @(posedge core_clk_i);
    #1;
    chk({31'h0, irq_o}, 32'h0);
    wr(uft_pkg::IRQ_MASK_IDX, 32'h4);
    repeat (2) @(posedge core_clk_i);
    #1;
    chk({31'h0, irq_o}, 32'h1);
    rd(uft_pkg::FRAME_COUNT_IDX, 1'b0);
    chk(v, 32'h1);
    ts();
    rd(uft_pkg::FRAME_TIME_LEFT_IDX, 1'b0);
    w = v;
    repeat (3) ts();
    rd(uft_pkg::FRAME_TIME_LEFT_IDX, 1'b0);
    chk(v, w - 32'h3);
    $display("test enter done");
    clr();
    wirq(0);
    rd(uft_pkg::FRAME_TIME_LEFT_IDX, 1'b0);
    chk({31'h0, v[31]}, 32'h1);
    wr(uft_pkg::FRAME_PERIOD_IDX, {18'h0, PB});
    clr();
    wirq(int'(PA) + 1);
    rd(uft_pkg::FRAME_TIME_LEFT_IDX, 1'b0);
    chk({31'h0, v[31]}, 32'h0);
    clr();
    wirq(int'(PB) + 1);
    rd(uft_pkg::FRAME_COUNT_IDX, 1'b0);
    chk(v, 32'h4);
    $display("test frames done");
    for (i = 0; i < 10; i++) begin
      u = (i == 0) ? 32'h0 : (i == 1) ? 32'h7ff : (rnd() & 32'h1f);
      wr(uft_pkg::LOWSPEED_CUTOFF_IDX, u);
      ts();
      rd(uft_pkg::FRAME_TIME_LEFT_IDX, 1'b1);
      chk({31'h0, g}, {31'h0, (v[13:0] >= u[13:0])});
    end
    rd(uft_pkg::LOWSPEED_CUTOFF_IDX, 1'b0);
    chk(v, u);
    $display("test gate done");
    wr(uft_pkg::CONTROL_IDX, 32'h0);
    rd(uft_pkg::FRAME_COUNT_IDX, 1'b0);
    w = v;
    rd(uft_pkg::FRAME_TIME_LEFT_IDX, 1'b0);
    u = v;
    repeat (3) ts();
    rd(uft_pkg::FRAME_TIME_LEFT_IDX, 1'b1);
    chk(v, u);
    chk({31'h0, g}, 32'h0);
    wr(uft_pkg::CONTROL_IDX, 32'h1);
    repeat (2) @(posedge core_clk_i);
    rd(uft_pkg::FRAME_COUNT_IDX, 1'b0);
    chk(v, w + 32'h1);
    rd(uft_pkg::FRAME_TIME_LEFT_IDX, 1'b0);
    chk({31'h0, v[13:0] >= PB - 14'd1}, 32'h1);
    $display("test halt done");
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(uft_pkg::FRAME_PERIOD_IDX, 1'b0);
    chk(v, 32'h2edf);
    $display("test rerst done");
    final_report();
  end
endmodule : uft_frame_timer_tb_top
